// ==== shared/pscb_pkg.sv ====
// Package for the specific configuration register block.
// Constants shared by the register slave and its helper modules.
package pscb_pkg;

    // Register map, byte addresses on the APB bus.
    localparam logic [7:0]  SPEC_CFG_OFF    = 8'h10;
    localparam logic [7:0]  STATUS_OFF      = 8'h14;

    // Field positions in the specific configuration register.
    localparam int          COLL_SEL_BIT    = 5;
    localparam int          ARPD_EN_BIT     = 4;
    localparam int          SM_RST_BIT      = 3;
    localparam int          PRE_SUP_BIT     = 2;
    localparam int          SLEEP_BIT       = 1;
    localparam int          LOOPOUT_BIT     = 0;

    // Reset values of the fields.
    localparam logic        COLL_SEL_RST    = 1'b0;
    localparam logic        ARPD_EN_RST     = 1'b1;
    localparam logic        SM_RST_RST      = 1'b0;
    localparam logic        PRE_SUP_RST     = 1'b1;
    localparam logic        SLEEP_RST       = 1'b0;
    localparam logic        LOOPOUT_RST     = 1'b0;

    // Width of the register and of the bus data.
    localparam int          REG_W           = 16;
    localparam int          DATA_W          = 32;

    // Length of a state machine reset pulse, in clock cycles.
    localparam int          SM_RST_CYCLES   = 4;

endpackage : pscb_pkg

// ==== src/pscb_pulse.sv ====
// Stretches a one-cycle request into a reset pulse of fixed length.
// Assumes a request arrives from logic on the same clock.
`timescale 1ns/1ns
module pscb_pulse #(
    parameter int LEN = pscb_pkg::SM_RST_CYCLES
) (
    // Clock and reset.
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Request and pulse.
    input  wire logic start_i,
    output logic      busy_o
);
    import pscb_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = 8'(LEN);
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != 8'h00);

endmodule : pscb_pulse

// ==== src/pscb_sync.sv ====
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the level is slow next to the 25 MHz clock.
`timescale 1ns/1ns
module pscb_sync (
    // Clock and reset.
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Level in and out.
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_q;
    logic s2_q;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;

endmodule : pscb_sync

// ==== src/pscb_top.sv ====
// APB slave holding the low six bits of the specific configuration register.
// Assumes one 25 MHz clock; duplex and collision come in from pins.
// Notes on behaviour
// R1 - Outside sleep, indicator shows duplex when select is 0, duplex or collision when 1; in sleep it is held at 0.
// R2 - Collision indicator select is bit 5, read/write, resets to 0.
// R3 - Auto reduced power-down only while bit 4 set; bit resets to 1.
// R4 - Writing 1 to bit 3 resets every internal state machine.
// R5 - Bit 3 resets to 0 and clears itself when the reset completes.
// R6 - Bit 2 resets to 1; 1 turns preamble suppression on, 0 off.
// R7 - Writing 1 to bit 1 enters sleep, powering down all but clocks and the register path.
// R8 - Writing 0 wakes; settings kept, state machines restart from reset.
// R9 - While bit 0 is 1 and bit 1 is 0, received data is looped back out.
// R10 - Register path stays alive during sleep so software can wake.
`timescale 1ns/1ns
module pscb_top (
    // Clock and reset.
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    // APB slave.
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [pscb_pkg::DATA_W-1:0] pwdata_i,
    output logic [pscb_pkg::DATA_W-1:0]    prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // Link status pins.
    input  wire logic                      full_duplex_i,
    input  wire logic                      collision_i,
    // Controls to the transceiver core.
    output logic                           duplex_collision_indicator_o,
    output logic                           auto_reduced_power_en_o,
    output logic                           sm_reset_o,
    output logic                           preamble_suppression_o,
    output logic                           sleep_o,
    output logic                           power_down_o,
    output logic                           remote_loopout_o
);
    import pscb_pkg::*;

    logic       coll_sel_q;
    logic       coll_sel_d;
    logic       arpd_en_q;
    logic       arpd_en_d;
    logic       pre_sup_q;
    logic       pre_sup_d;
    logic       sleep_q;
    logic       sleep_d;
    logic       loopout_q;
    logic       loopout_d;
    logic       ind_q;
    logic       ind_d;
    logic       start_rst;
    logic       rst_busy;
    logic       fdx_s;
    logic       col_s;
    logic       wr_en;
    logic       rd_en;
    logic       hit_cfg;
    logic       hit_sts;
    logic [REG_W-1:0] cfg_val;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    pscb_sync u_sync_fdx (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (full_duplex_i),
        .q_o    (fdx_s)
    );

    pscb_sync u_sync_col (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (collision_i),
        .q_o    (col_s)
    );

    // The bus answers in its first access cycle and never stalls, so the
    // register path does not depend on anything that sleep powers down.
    assign pready_o  = 1'b1; // R10
    assign hit_cfg   = (paddr_i == SPEC_CFG_OFF);
    assign hit_sts   = (paddr_i == STATUS_OFF);
    assign wr_en     = psel_i & penable_i & pwrite_i & hit_cfg;
    assign rd_en     = psel_i & ~pwrite_i;
    assign pslverr_o = psel_i & penable_i & ~(hit_cfg | (hit_sts & ~pwrite_i));

    // A write of 1 to the reset bit, or waking from sleep, starts a pulse.
    assign start_rst = (wr_en & pwdata_i[SM_RST_BIT]) // R4
                     | (wr_en & sleep_q & ~pwdata_i[SLEEP_BIT]); // R8

    pscb_pulse #(
        .LEN (SM_RST_CYCLES)
    ) u_pulse (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .start_i (start_rst),
        .busy_o  (rst_busy)
    );

    always_comb begin
        cfg_val = '0;
        cfg_val[COLL_SEL_BIT] = coll_sel_q;
        cfg_val[ARPD_EN_BIT]  = arpd_en_q;
        cfg_val[SM_RST_BIT]   = rst_busy; // R5
        cfg_val[PRE_SUP_BIT]  = pre_sup_q;
        cfg_val[SLEEP_BIT]    = sleep_q;
        cfg_val[LOOPOUT_BIT]  = loopout_q;
    end

    always_comb begin
        coll_sel_d = coll_sel_q;
        arpd_en_d  = arpd_en_q;
        pre_sup_d  = pre_sup_q;
        sleep_d    = sleep_q;
        loopout_d  = loopout_q;
        // Configuration bits are not touched by sleep, so they survive it.
        if (wr_en) begin
            coll_sel_d = pwdata_i[COLL_SEL_BIT]; // R2
            arpd_en_d  = pwdata_i[ARPD_EN_BIT]; // R3
            pre_sup_d  = pwdata_i[PRE_SUP_BIT]; // R6
            sleep_d    = pwdata_i[SLEEP_BIT]; // R7
            loopout_d  = pwdata_i[LOOPOUT_BIT]; // R9
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (rd_en & ~penable_i) begin
            rdata_d = '0;
            if (hit_cfg) begin
                rdata_d = {{(DATA_W-REG_W){1'b0}}, cfg_val};
            end else if (hit_sts) begin
                rdata_d = {30'h0, col_s, fdx_s};
            end
        end
    end

    // Indicator: plain duplex, or duplex combined with collision.
    always_comb begin
        if (coll_sel_q) begin
            ind_d = fdx_s | col_s; // R1
        end else begin
            ind_d = fdx_s; // R1
        end
        if (sleep_q) begin
            ind_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            coll_sel_q <= COLL_SEL_RST; // R2
            arpd_en_q  <= ARPD_EN_RST; // R3
            pre_sup_q  <= PRE_SUP_RST; // R6
            sleep_q    <= SLEEP_RST;
            loopout_q  <= LOOPOUT_RST;
            ind_q      <= 1'b0;
            rdata_q    <= '0;
        end else begin
            coll_sel_q <= coll_sel_d;
            arpd_en_q  <= arpd_en_d;
            pre_sup_q  <= pre_sup_d;
            sleep_q    <= sleep_d;
            loopout_q  <= loopout_d;
            ind_q      <= ind_d;
            rdata_q    <= rdata_d;
        end
    end

    assign prdata_o                     = rdata_q;
    assign duplex_collision_indicator_o = ind_q;
    assign auto_reduced_power_en_o      = arpd_en_q & ~sleep_q; // R3
    assign sm_reset_o                   = rst_busy | sleep_q; // R4
    assign preamble_suppression_o       = pre_sup_q;
    assign sleep_o                      = sleep_q;
    assign power_down_o                 = sleep_q; // R7
    assign remote_loopout_o             = loopout_q & ~sleep_q; // R9

endmodule : pscb_top

// ==== tb/pscb_top_checker.sv ====
// Assertions on the ports of the configuration register block.
// Assumes one clock, mclk_i, and rst_i active high.
`timescale 1ns/1ns
module pscb_top_checker
    import pscb_pkg::*;
(
    input wire logic                        mclk_i,
    input wire logic                        rst_i,
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [7:0]                  paddr_i,
    input wire logic [pscb_pkg::DATA_W-1:0] pwdata_i,
    input wire logic                        pready_o,
    input wire logic                        pslverr_o,
    input wire logic                        duplex_collision_indicator_o,
    input wire logic                        auto_reduced_power_en_o,
    input wire logic                        sm_reset_o,
    input wire logic                        preamble_suppression_o,
    input wire logic                        sleep_o,
    input wire logic                        power_down_o,
    input wire logic                        remote_loopout_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic wr;
    assign wr = psel_i & penable_i & pwrite_i & (paddr_i == SPEC_CFG_OFF);
    property p_ind;
        sleep_o && $past(sleep_o) |-> !duplex_collision_indicator_o;
    endproperty
    a_ind: assert property (p_ind) else $error("indicator lit in sleep");
    property p_arpd;
        wr |=> auto_reduced_power_en_o == ($past(pwdata_i[4]) & !sleep_o);
    endproperty
    a_arpd: assert property (p_arpd) else $error("power enable wrong");
    property p_smr;
        wr && pwdata_i[SM_RST_BIT] |=> sm_reset_o;
    endproperty
    a_smr: assert property (p_smr) else $error("no reset pulse");
    property p_pulse;
        $rose(sm_reset_o) |-> sm_reset_o[*4];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too short");
    property p_pre;
        wr |=> preamble_suppression_o == $past(pwdata_i[PRE_SUP_BIT]);
    endproperty
    a_pre: assert property (p_pre) else $error("suppression wrong");
    property p_slp;
        wr |=> sleep_o == $past(pwdata_i[SLEEP_BIT]) && power_down_o == sleep_o;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep wrong");
    property p_wake;
        $fell(sleep_o) |-> ##[0:1] sm_reset_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no reset on wake");
    property p_loop;
        wr && pwdata_i[1:0] == 2'h1 |=> remote_loopout_o;
    endproperty
    a_loop: assert property (p_loop) else $error("loop-out off");
    property p_live;
        sleep_o && psel_i && penable_i |-> pready_o;
    endproperty
    a_live: assert property (p_live) else $error("bus dead in sleep");
    c_smr: cover property (wr && pwdata_i[SM_RST_BIT]);
    c_wake: cover property ($fell(sleep_o));
    c_err: cover property (pslverr_o);
endmodule : pscb_top_checker

bind pscb_top pscb_top_checker i_chk (.*);

// ==== tb/tb_pscb_top.sv ====
// Bench for the configuration register block, with a model in integers.
// Drives APB and the status pins from one 25 MHz clock.
`timescale 1ns/1ns
module tb_pscb_top;
    import pscb_pkg::*;
    logic        mclk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0;
    logic        fdx = 0, col = 0, pready, perr, err;
    logic        ind, arpd, smr, pre, slp, pd, lpo;
    logic [7:0]  pa = 0;
    logic [31:0] pwd = 0, rdat, prdata;
    int          err_total = 0, n_compared = 0, cyc = 0, cfg = 'h14, n;
    pscb_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .full_duplex_i(fdx), .collision_i(col),
        .duplex_collision_indicator_o(ind), .auto_reduced_power_en_o(arpd),
        .sm_reset_o(smr), .preamble_suppression_o(pre), .sleep_o(slp),
        .power_down_o(pd), .remote_loopout_o(lpo));
    initial forever #20 mclk_i = ~mclk_i;
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Waits one edge first, so back-to-back calls never collide.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk_i);
        pen <= 1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rdat = prdata;
        err = perr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    function automatic logic [5:0] model(int c);
        logic s = c[1];
        return {s ? 1'b0 : fdx | (col & c[5]), c[4] & !s, c[2], s, s,
                c[0] & !s};
    endfunction : model
    task automatic cmp_all();
        apb(0, SPEC_CFG_OFF, 0);
        chk("cfg", rdat, cfg);
        chk("pins", {ind, arpd, pre, slp, pd, lpo}, model(cfg));
        chk("smr", smr, cfg[1]);
    endtask : cmp_all
    task automatic count_pulse(int e);
        n = 0;
        repeat (8) begin
            #1 n += smr;
            @(posedge mclk_i);
        end
        chk("pulse", n, e);
    endtask : count_pulse
    initial begin
        void'($urandom(79));
        repeat (8) @(posedge mclk_i);
        rst_i <= 0;
        cmp_all();
        $display("test reset done");
        repeat (20) begin
            n = $urandom;
            fdx <= n[8];
            col <= n[9];
            apb(1, SPEC_CFG_OFF, n);
            cfg = n & 'h37;
            repeat (6) @(posedge mclk_i);
            cmp_all();
        end
        $display("test random done");
        apb(1, SPEC_CFG_OFF, 'h08);
        cfg = 0;
        count_pulse(4);
        cmp_all();
        apb(1, SPEC_CFG_OFF, 'h37);
        cfg = 'h37;
        cmp_all();
        apb(1, SPEC_CFG_OFF, 'h31);
        cfg = 'h31;
        count_pulse(4);
        cmp_all();
        $display("test sleep done");
        apb(1, 8'h20, 'h3f);
        chk("wr_err", err, 1);
        apb(0, 8'h20, 0);
        chk("rd_err", err, 1);
        chk("rd_unm", rdat, 0);
        apb(0, STATUS_OFF, 0);
        chk("status", rdat, {col, fdx});
        cmp_all();
        $display("test map done");
        report_and_stop();
    end
endmodule : tb_pscb_top
